/* File: core/mlb_map.svh */
// Constant map for the multiplexed local bus interface
`ifndef MLB_MAP_SVH
`define MLB_MAP_SVH
`define MLB_ADDR_W 20
`define MLB_LO_HI 7
`define MLB_MID_LO 8
`define MLB_MID_HI 15
`define MLB_TOP_LO 16
`define MLB_TOP_HI 19
`define MLB_SEG_ALT 2'h0
`define MLB_SEG_STACK 2'h1
`define MLB_SEG_CODE 2'h2
`define MLB_SEG_DATA 2'h3
`define MLB_NMI_TYPE 8'h02
`define MLB_RESET_CLOCKS 3'h4
`endif

/* File: core/mlb_pkg.sv */
// Types for the multiplexed local bus interface
package mlb_pkg;
    typedef enum logic [1:0] {
        MLB_CYC_READ,
        MLB_CYC_WRITE,
        MLB_CYC_IACK
    } mlb_cyc_t;
    typedef enum logic [2:0] {
        MLB_TI,
        MLB_T1,
        MLB_T2,
        MLB_T3,
        MLB_TW,
        MLB_T4,
        MLB_THOLD
    } mlb_state_t;
endpackage : mlb_pkg

/* File: core/mlb_sync2.sv */
// Two flip-flop synchroniser for a single level
module mlb_sync2 (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_reg;
    logic q_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            q_reg <= 1'b0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
    assign q = q_reg;
endmodule : mlb_sync2

/* File: core/mlb_bus_if.sv */
// Bus cycle sequencer, strobes, hold handover and input sampling
// Summary of operation
// - Low mux lines carry address in T1, data after; float in int-ack and hold.
// - Address bits 8-15 valid whole cycle; float in int-ack and hold.
// - Top lines: address (zero for I/O) in T1, status later; float in hold.
// - Spare status always low; next bit mirrors interrupt enable each clock.
// - Segment status: 00 alternate, 01 stack, 10 code/none, 11 data.
// - Read strobe low T2, T3, Tw of reads; floats in hold.
// - Ready low inserts wait states; ready high ends the transfer.
// - Maskable request synchronised, sampled at instruction end, gated by enable.
// - Synchronised rising edge on nmi raises a type 2 interrupt, unmaskable.
// - Test input synchronised; wait-for-test proceeds when low, idles when high.
// - Reset held four clocks; synchronised; stops activity; restarts at release.
// - Strap high selects minimum mode with strobes driven here.
// - Space select high for I/O and int-ack, valid from T1 to final T4; floats in hold.
// - Write strobe low T2, T3, Tw of writes; floats in hold.
// - Interrupt acknowledge strobe low in T2, T3, Tw of ack cycles.
// - Address latch strobe high in T1; never floated.
// - Transceiver direction high transmit, low receive; floats in hold.
// - Transceiver enable low for accesses, from T2 to T4; floats in hold.
// - Hold high gets grant at a T4 or Ti edge, bus floats then.
// - Hold low drops grant; bus driven again at next needed cycle.
`include "mlb_map.svh"
module mlb_bus_if
    import mlb_pkg::*;
#(
    parameter int ADDR_W = `MLB_ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic min_max_strap,
    input wire logic req_valid,
    input wire mlb_pkg::mlb_cyc_t req_kind,
    input wire logic req_io,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [1:0] req_segment,
    input wire logic int_enable,
    input wire logic instr_last,
    input wire logic wait_for_test,
    input wire logic ready,
    input wire logic hold,
    input wire logic maskable_irq,
    input wire logic nmi,
    input wire logic test_n,
    input wire logic [7:0] mux_addr_data_in,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic irq_take,
    output logic nmi_take,
    output logic [7:0] nmi_type,
    output logic test_stall,
    output logic cpu_reset,
    output logic [7:0] mux_addr_data,
    output logic mux_addr_data_oe,
    output logic [7:0] mid_address,
    output logic mid_address_oe,
    output logic [3:0] top_addr_status,
    output logic top_addr_status_oe,
    output logic io_select,
    output logic rd_strobe_n,
    output logic wr_strobe_n,
    output logic irq_ack_strobe_n,
    output logic ctrl_oe,
    output logic addr_latch,
    output logic xcvr_direction,
    output logic xcvr_enable_n,
    output logic bus_grant
);
    import mlb_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic irq_s;
    logic nmi_s;
    logic test_s;
    logic rst_s;
    logic strap_s;
    mlb_sync2 u_sync_irq (.clk(clk), .rst(rst), .d(maskable_irq), .q(irq_s));
    mlb_sync2 u_sync_nmi (.clk(clk), .rst(rst), .d(nmi), .q(nmi_s));
    mlb_sync2 u_sync_test (.clk(clk), .rst(rst), .d(test_n), .q(test_s));
    mlb_sync2 u_sync_strap (.clk(clk), .rst(rst), .d(min_max_strap), .q(strap_s));
    // Reset synchroniser: set asynchronously, release through two stages
    logic [1:0] rst_pipe_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_pipe_reg <= 2'h3;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b0};
        end
    end
    assign rst_s = rst_pipe_reg[1];

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    mlb_state_t state_reg, state_next;
    mlb_cyc_t kind_reg, kind_next;
    logic io_reg, io_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [1:0] seg_reg, seg_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rsp_reg, rsp_next;
    logic grant_reg, grant_next;
    logic nmi_prev_reg, nmi_prev_next;
    logic nmi_pend_reg, nmi_pend_next;
    logic irq_take_reg, irq_take_next;
    logic nmi_take_reg, nmi_take_next;
    logic stall_reg, stall_next;
    logic ie_reg, ie_next;
    logic minmode_reg, minmode_next;
    logic accept;
    logic nmi_rise;

    assign nmi_rise = nmi_s & ~nmi_prev_reg;
    assign accept = req_valid & ~hold & ~rst_s & minmode_reg
        & ((state_reg == MLB_TI) | (state_reg == MLB_T4) | (state_reg == MLB_THOLD));

    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        io_next = io_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        seg_next = seg_reg;
        rdata_next = rdata_reg;
        rsp_next = 1'b0;
        grant_next = grant_reg;
        nmi_prev_next = nmi_s;
        nmi_pend_next = nmi_pend_reg | nmi_rise;
        irq_take_next = 1'b0;
        nmi_take_next = 1'b0;
        stall_next = wait_for_test & test_s;
        ie_next = int_enable;
        minmode_next = strap_s;
        if (instr_last) begin
            nmi_take_next = nmi_pend_reg | nmi_rise;
            nmi_pend_next = 1'b0;
            irq_take_next = irq_s & int_enable & ~(nmi_pend_reg | nmi_rise);
        end
        case (state_reg)
            MLB_TI, MLB_T4, MLB_THOLD: begin
                if (hold) begin
                    state_next = MLB_THOLD;
                    grant_next = 1'b1;
                end else if (accept) begin
                    state_next = MLB_T1;
                    grant_next = 1'b0;
                    kind_next = req_kind;
                    io_next = req_io;
                    addr_next = req_addr;
                    wdata_next = req_wdata;
                    seg_next = req_segment;
                end else if (state_reg == MLB_T4) begin
                    state_next = MLB_TI;
                end else if (state_reg == MLB_THOLD) begin
                    grant_next = 1'b0;
                end
            end
            MLB_T1: state_next = MLB_T2;
            MLB_T2: state_next = MLB_T3;
            MLB_T3, MLB_TW: begin
                if (ready) begin
                    state_next = MLB_T4;
                    rsp_next = 1'b1;
                    rdata_next = mux_addr_data_in;
                end else begin
                    state_next = MLB_TW;
                end
            end
            default: state_next = MLB_TI;
        endcase
        if (rst_s) begin
            state_next = MLB_TI;
            grant_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= MLB_TI;
            kind_reg <= MLB_CYC_READ;
            io_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= 8'h00;
            seg_reg <= `MLB_SEG_CODE;
            rdata_reg <= 8'h00;
            rsp_reg <= 1'b0;
            grant_reg <= 1'b0;
            nmi_prev_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
            irq_take_reg <= 1'b0;
            nmi_take_reg <= 1'b0;
            stall_reg <= 1'b0;
            ie_reg <= 1'b0;
            minmode_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            io_reg <= io_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            seg_reg <= seg_next;
            rdata_reg <= rdata_next;
            rsp_reg <= rsp_next;
            grant_reg <= grant_next;
            nmi_prev_reg <= nmi_prev_next;
            nmi_pend_reg <= nmi_pend_next;
            irq_take_reg <= irq_take_next;
            nmi_take_reg <= nmi_take_next;
            stall_reg <= stall_next;
            ie_reg <= ie_next;
            minmode_reg <= minmode_next;
        end
    end

    // ------------------------------------------------------------
    // Pin outputs, registered from the next state
    // ------------------------------------------------------------
    logic [7:0] mad_next;
    logic mad_oe_next;
    logic [7:0] mid_next;
    logic mid_oe_next;
    logic [3:0] top_next;
    logic top_oe_next;
    logic rd_next;
    logic wr_next;
    logic ack_next;
    logic ale_next;
    logic dir_next;
    logic den_next;
    logic ctrl_oe_next;
    logic in_cycle;
    logic is_ack;
    logic active_t2_tw;
    logic [7:0] mad_reg;
    logic mad_oe_reg;
    logic [7:0] mid_reg;
    logic mid_oe_reg;
    logic [3:0] top_reg;
    logic top_oe_reg;
    logic rd_reg;
    logic wr_reg;
    logic ack_reg;
    logic ale_reg;
    logic dir_reg;
    logic den_reg;
    logic ctrl_oe_reg;
    logic iosel_reg;

    always_comb begin
        in_cycle = (state_next != MLB_TI) & (state_next != MLB_THOLD);
        is_ack = (kind_next == MLB_CYC_IACK);
        active_t2_tw = (state_next == MLB_T2) | (state_next == MLB_T3)
            | (state_next == MLB_TW);
        ctrl_oe_next = ~grant_next & (state_next != MLB_THOLD);
        mad_oe_next = in_cycle & ~grant_next & ~is_ack
            & ((state_next == MLB_T1) | (kind_next == MLB_CYC_WRITE));
        mad_next = (state_next == MLB_T1) ? addr_next[`MLB_LO_HI:0] : wdata_next;
        mid_oe_next = in_cycle & ~grant_next & ~is_ack;
        mid_next = addr_next[`MLB_MID_HI:`MLB_MID_LO];
        top_oe_next = ctrl_oe_next;
        if (state_next == MLB_T1) begin
            top_next = io_next ? 4'h0 : addr_next[`MLB_TOP_HI:`MLB_TOP_LO];
        end else begin
            top_next = {1'b0, ie_next, seg_next};
        end
        rd_next = ~(active_t2_tw & (kind_next == MLB_CYC_READ));
        wr_next = ~(active_t2_tw & (kind_next == MLB_CYC_WRITE));
        ack_next = ~(active_t2_tw & is_ack);
        ale_next = (state_next == MLB_T1);
        dir_next = (kind_next == MLB_CYC_WRITE);
        den_next = ~(active_t2_tw | (state_next == MLB_T4 & state_reg != MLB_T4));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mad_reg <= 8'h00;
            mad_oe_reg <= 1'b0;
            mid_reg <= 8'h00;
            mid_oe_reg <= 1'b0;
            top_reg <= 4'h0;
            top_oe_reg <= 1'b0;
            rd_reg <= 1'b1;
            wr_reg <= 1'b1;
            ack_reg <= 1'b1;
            ale_reg <= 1'b0;
            dir_reg <= 1'b0;
            den_reg <= 1'b1;
            ctrl_oe_reg <= 1'b0;
            iosel_reg <= 1'b0;
        end else begin
            mad_reg <= mad_next;
            mad_oe_reg <= mad_oe_next;
            mid_reg <= mid_next;
            mid_oe_reg <= mid_oe_next;
            top_reg <= top_next;
            top_oe_reg <= top_oe_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            ack_reg <= ack_next;
            ale_reg <= ale_next;
            dir_reg <= dir_next;
            den_reg <= den_next;
            ctrl_oe_reg <= ctrl_oe_next;
            iosel_reg <= io_next | (kind_next == MLB_CYC_IACK);
        end
    end

    assign req_ready = accept;
    assign rsp_valid = rsp_reg;
    assign rsp_rdata = rdata_reg;
    assign irq_take = irq_take_reg;
    assign nmi_take = nmi_take_reg;
    assign nmi_type = `MLB_NMI_TYPE;
    assign test_stall = stall_reg;
    assign cpu_reset = rst_s;
    assign mux_addr_data = mad_reg;
    assign mux_addr_data_oe = mad_oe_reg;
    assign mid_address = mid_reg;
    assign mid_address_oe = mid_oe_reg;
    assign top_addr_status = top_reg;
    assign top_addr_status_oe = top_oe_reg;
    assign io_select = iosel_reg;
    assign rd_strobe_n = rd_reg;
    assign wr_strobe_n = wr_reg;
    assign irq_ack_strobe_n = ack_reg;
    assign ctrl_oe = ctrl_oe_reg;
    assign addr_latch = ale_reg;
    assign xcvr_direction = dir_reg;
    assign xcvr_enable_n = den_reg;
    assign bus_grant = grant_reg;
endmodule : mlb_bus_if

/* File: tb/mlb_bus_if_props.sv */
// Concurrent checks on the ports of the local bus interface
module mlb_bus_if_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire mlb_pkg::mlb_cyc_t req_kind,
    input wire logic req_io,
    input wire logic [1:0] req_segment,
    input wire logic int_enable,
    input wire logic ready,
    input wire logic hold,
    input wire logic rsp_valid,
    input wire logic mux_addr_data_oe,
    input wire logic mid_address_oe,
    input wire logic [3:0] top_addr_status,
    input wire logic top_addr_status_oe,
    input wire logic io_select,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic irq_ack_strobe_n,
    input wire logic ctrl_oe,
    input wire logic addr_latch,
    input wire logic xcvr_direction,
    input wire logic xcvr_enable_n,
    input wire logic bus_grant
);
    timeunit 1ns;
    timeprecision 1ps;
    import mlb_pkg::*;
    logic take;
    logic [1:0] seg_reg;
    assign take = req_valid && req_ready;
    always_ff @(posedge clk) begin
        if (take) begin
            seg_reg <= req_segment;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_latch_pulse: assert property (take |=> addr_latch ##1 !addr_latch)
        else $error("latch pulse wrong");
    a_read_strobe: assert property (take && req_kind == MLB_CYC_READ
        |=> rd_strobe_n ##1 (!rd_strobe_n && !xcvr_direction)) else $error("read strobe wrong");
    a_write_strobe: assert property (take && req_kind == MLB_CYC_WRITE
        |-> ##2 !wr_strobe_n && xcvr_direction && !xcvr_enable_n) else $error("write wrong");
    a_iack_float: assert property (take && req_kind == MLB_CYC_IACK
        |-> ##2 !irq_ack_strobe_n && !mux_addr_data_oe && !mid_address_oe) else $error("ack");
    a_wait_state: assert property (ctrl_oe && !rd_strobe_n && !ready |=> !rd_strobe_n)
        else $error("wait state lost");
    a_status_bits: assert property (!(rd_strobe_n && wr_strobe_n) && top_addr_status_oe
        |-> top_addr_status == {1'b0, $past(int_enable), seg_reg}) else $error("status wrong");
    a_space_select: assert property (take && req_kind != MLB_CYC_IACK
        |=> io_select == $past(req_io) && (!io_select || top_addr_status == 4'h0))
        else $error("space select wrong");
    a_rsp_ready: assert property (take ##3 ready |=> rsp_valid)
        else $error("no response");
    a_grant_float: assert property (bus_grant
        |-> !ctrl_oe && !mux_addr_data_oe && !mid_address_oe && !top_addr_status_oe)
        else $error("bus not floated");
    a_grant_drop: assert property (bus_grant && !hold |=> !bus_grant)
        else $error("grant kept");
    a_hold_refuse: assert property (hold |-> !req_ready)
        else $error("taken in hold");
endmodule : mlb_bus_if_props

bind mlb_bus_if mlb_bus_if_props i_mlb_bus_if_props (.clk, .rst, .req_valid, .req_ready,
    .req_kind, .req_io, .req_segment, .int_enable, .ready, .hold, .rsp_valid,
    .mux_addr_data_oe, .mid_address_oe, .top_addr_status, .top_addr_status_oe, .io_select,
    .rd_strobe_n, .wr_strobe_n, .irq_ack_strobe_n, .ctrl_oe, .addr_latch, .xcvr_direction,
    .xcvr_enable_n, .bus_grant);

/* File: tb/mlb_mem_model.sv */
// Memory and I/O responder on the far side of the local bus
module mlb_mem_model #(
    parameter logic [7:0] VEC = 8'h5c
) (
    input wire logic clk,
    input wire logic [7:0] mux_addr_data,
    input wire logic [7:0] mid_address,
    input wire logic addr_latch,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic irq_ack_strobe_n,
    input wire logic xcvr_enable_n,
    input wire logic [1:0] waits,
    output logic ready,
    output logic [7:0] rdata,
    output logic [7:0] wseen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lo_reg, mid_reg;
    logic [7:0] last_reg = 8'h00;
    logic [2:0] cnt_reg = 3'h0;
    logic drive;
    assign drive = !xcvr_enable_n && !(rd_strobe_n && irq_ack_strobe_n);
    // Ready counts strobe cycles, so waits sets the stall length
    assign ready = cnt_reg >= {1'b0, waits};
    // Released lines show the inverse of the last byte driven
    assign rdata = drive ? (irq_ack_strobe_n ? lo_reg ^ mid_reg : VEC) : ~last_reg;
    always @(posedge clk) begin
        if (addr_latch) begin
            lo_reg <= mux_addr_data;
            mid_reg <= mid_address;
        end
        if (drive) begin
            last_reg <= rdata;
        end
        if (!wr_strobe_n) begin
            wseen <= mux_addr_data;
        end
        cnt_reg <= (rd_strobe_n && wr_strobe_n && irq_ack_strobe_n) ? 3'h0 : cnt_reg + 3'h1;
    end
endmodule : mlb_mem_model

/* File: tb/mlb_bus_if_test.sv */
// Self-checking bench for the local bus interface
module mlb_bus_if_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mlb_pkg::*;
    localparam logic [7:0] VEC = 8'h5c;
    logic clk, rst, req_valid, req_io, int_enable, instr_last, wait_for_test, ready, hold;
    logic maskable_irq, nmi, test_n, req_ready, rsp_valid, irq_take, nmi_take, test_stall;
    logic cpu_reset, mux_addr_data_oe, mid_address_oe, top_addr_status_oe, io_select, ctrl_oe;
    logic rd_strobe_n, wr_strobe_n, irq_ack_strobe_n, addr_latch, xcvr_direction;
    logic xcvr_enable_n, bus_grant, min_max_strap;
    mlb_cyc_t req_kind;
    logic [19:0] req_addr;
    logic [7:0] req_wdata, mux_addr_data_in, rsp_rdata, nmi_type, mux_addr_data, mid_address;
    logic [7:0] wseen;
    logic [3:0] top_addr_status;
    logic [1:0] req_segment, waits;
    logic [8:0] notes[$];
    logic [8:0] note;
    logic [31:0] seed;
    int n_fail, comparisons;

    mlb_bus_if i_mlb_bus_if (.clk, .rst, .min_max_strap, .req_valid, .req_kind, .req_io,
        .req_addr, .req_wdata, .req_segment, .int_enable, .instr_last, .wait_for_test, .ready,
        .hold, .maskable_irq, .nmi, .test_n, .mux_addr_data_in, .req_ready, .rsp_valid,
        .rsp_rdata, .irq_take, .nmi_take, .nmi_type, .test_stall, .cpu_reset, .mux_addr_data,
        .mux_addr_data_oe, .mid_address, .mid_address_oe, .top_addr_status,
        .top_addr_status_oe, .io_select, .rd_strobe_n, .wr_strobe_n, .irq_ack_strobe_n,
        .ctrl_oe, .addr_latch, .xcvr_direction, .xcvr_enable_n, .bus_grant);
    mlb_mem_model #(.VEC(VEC)) i_mlb_mem_model (.clk, .mux_addr_data, .mid_address,
        .addr_latch, .rd_strobe_n, .wr_strobe_n, .irq_ack_strobe_n, .xcvr_enable_n, .waits,
        .ready, .rdata(mux_addr_data_in), .wseen);

    initial begin
        clk = 1'b0;
        // High phase is one third of the 50 ns period
        forever begin
            #33.5 clk = ~clk;
            #16.5 clk = ~clk;
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Holds the request until it is taken; the caller lowers req_valid
    task automatic bus_op(input mlb_cyc_t k, input logic io, input logic [19:0] a,
        input logic [7:0] d);
        int n;
        logic [31:0] r;
        r = xs();
        req_valid <= 1'b1;
        req_kind <= k;
        req_io <= io;
        req_addr <= a;
        req_wdata <= d;
        req_segment <= r[1:0];
        int_enable <= r[2];
        waits <= r[4:3];
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
        end
        if (k == MLB_CYC_WRITE) begin
            notes.push_back({1'b1, d});
        end else begin
            notes.push_back({1'b0, k == MLB_CYC_IACK ? VEC : a[7:0] ^ a[15:8]});
        end
    endtask : bus_op

    task automatic pulse_last();
        instr_last <= 1'b1;
        @(posedge clk);
        instr_last <= 1'b0;
        @(negedge clk);
    endtask : pulse_last

    always @(posedge clk) begin
        if (rsp_valid === 1'b1) begin
            if (notes.size() == 0) begin
                chk("surplus response", 8'h00, 8'h01);
            end else begin
                note = notes.pop_front();
                chk("transfer data", note[7:0], note[8] ? wseen : rsp_rdata);
            end
        end
    end

    initial begin
        #(4000 * 50);
        n_fail++;
        give_verdict();
    end

    initial begin
        int n;
        logic [31:0] r;
        {rst, min_max_strap, test_n} = 3'h7;
        {req_valid, req_io, int_enable, instr_last, wait_for_test, hold, maskable_irq, nmi} = '0;
        req_kind = MLB_CYC_READ;
        {req_addr, req_wdata, req_segment, waits} = '0;
        {seed, n_fail, comparisons} = {32'h43a3ce22, 64'h0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("grant after reset", 8'h00, {7'h0, bus_grant});
        chk("read strobe after reset", 8'h01, {7'h0, rd_strobe_n});
        chk("cpu reset held", 8'h01, {7'h0, cpu_reset});
        repeat (3) @(posedge clk);
        chk("cpu reset released", 8'h00, {7'h0, cpu_reset});
        for (int i = 0; i < 24; i++) begin
            r = xs();
            bus_op(mlb_cyc_t'(i % 3), r[0], r[31:12], r[11:4]);
        end
        req_valid <= 1'b0;
        repeat (8) @(posedge clk);
        hold <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (bus_grant !== 1'b1 && n < 20);
        chk("control enable in hold", 8'h00, {7'h0, ctrl_oe});
        fork
            begin
                repeat (6) @(posedge clk);
                hold <= 1'b0;
            end
            bus_op(MLB_CYC_READ, 1'b0, 20'h3c5a7, 8'h00);
        join
        req_valid <= 1'b0;
        repeat (8) @(posedge clk);
        chk("grant after hold", 8'h00, {7'h0, bus_grant});
        maskable_irq <= 1'b1;
        int_enable <= 1'b1;
        repeat (4) @(posedge clk);
        pulse_last();
        chk("irq taken", 8'h01, {7'h0, irq_take});
        @(posedge clk);
        int_enable <= 1'b0;
        repeat (2) @(posedge clk);
        pulse_last();
        chk("irq masked", 8'h00, {7'h0, irq_take});
        @(posedge clk);
        maskable_irq <= 1'b0;
        nmi <= 1'b1;
        repeat (4) @(posedge clk);
        pulse_last();
        chk("nmi taken", 8'h01, {7'h0, nmi_take});
        chk("nmi type", 8'h02, nmi_type);
        @(posedge clk);
        pulse_last();
        chk("nmi level only", 8'h00, {7'h0, nmi_take});
        @(posedge clk);
        wait_for_test <= 1'b1;
        repeat (4) @(posedge clk);
        chk("test idle", 8'h01, {7'h0, test_stall});
        test_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk("test go", 8'h00, {7'h0, test_stall});
        min_max_strap <= 1'b0;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        req_valid <= 1'b1;
        repeat (6) begin
            @(posedge clk);
            chk("accept in maximum mode", 8'h00, {7'h0, req_ready});
        end
        give_verdict();
    end
endmodule : mlb_bus_if_test
